// ### hw/osfsr_core.sv
// Status reporting core: per-output status units, poll summary and service request.
// Commands arrive already parsed on clk_sys; status, dropout and stored
// power-on enable are pins and are synchronised before use.
//
// Contract
// - Cumulative status ORs in every live status bit seen since last read.
// - Reading cumulative status returns it, then reloads it with live status.
// - All per-output registers share one 8-bit status bit layout.
// - Mask written only by controller; live status not writable.
// - Fault bit sets when live bit rises while mask bit is one.
// - Unmasking a bit already live sets its fault bit.
// - Fault register clears on read and stays clear until a change.
// - Reprogramming commands set applicable regulation fault bits anew.
// - Fault bits stay set after cause goes, until read.
// - Poll bits 0 to 3 are per-output fault summaries.
// - Summaries of outputs absent in smaller builds read zero.
// - Poll bit 4 ready: set when processing done, clear while busy.
// - Poll bit 5 error: set on error, cleared by error query; lamp follows.
// - Poll bit 6 request: set on service request, cleared by serial poll.
// - Poll bit 7 power-on: set at power-up, cleared by device clear.
// - Enabled request sets request flag, service lamp and bus request line.
// - Two-bit request enable: 0 none, 1 faults, 2 errors, 3 both; readable.
// - Faults request only at enable 1 or 3; errors at 2 or 3.
// - Power-up sets power-on flag; requests only if power-on enable set.
// - Line dropout acts exactly like power-up; code sets power-on flag, requests per current enable, no enable reload.
// - Power-on enable kept non-volatile, restored at power-up, readable.
// - Serial poll clears request flag but leaves fault registers alone.
`timescale 1ns/100ps
`default_nettype none
module osfsr_core
  import osfsr_pkg::*;
#(
  parameter int NUM_OUT = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [NUM_OUT*OSFSR_W-1:0] live_status_pins,
  input wire logic dropout_pin,
  input wire logic nv_pon_pin,
  input wire logic busy,
  input wire logic error_event,
  input wire logic cmd_valid,
  input wire osfsr_op_t cmd_op,
  input wire logic [OSFSR_CHAN_W-1:0] cmd_chan,
  input wire logic [7:0] cmd_data,
  output logic resp_valid,
  output logic [7:0] resp_data,
  output logic srq_out,
  output logic srq_lamp,
  output logic err_lamp,
  output logic nv_pon_store,
  output logic [7:0] poll_byte
);

  // ==========================================================================
  // Decoding
  function automatic logic chan_hit(input osfsr_op_t op, input osfsr_op_t want,
                                    input logic [OSFSR_CHAN_W-1:0] chan, input int idx);
    chan_hit = (op == want) && (int'(chan) == idx);
  endfunction : chan_hit

  // ==========================================================================
  // Channel units
  logic [7:0] live_arr [OSFSR_MAX_OUT];
  logic [7:0] cum_arr [OSFSR_MAX_OUT];
  logic [7:0] mask_arr [OSFSR_MAX_OUT];
  logic [7:0] fault_arr [OSFSR_MAX_OUT];
  logic [OSFSR_MAX_OUT-1:0] fault_summary;
  logic do_clear;
  logic do_reprog;

  assign do_clear = cmd_valid && (cmd_op == OP_DEVICE_CLEAR);
  assign do_reprog = cmd_valid && (cmd_op == OP_REPROGRAM);

  // ==========================================================================
  // Command strobes
  // Core operations are decoded once here; channel read and mask-write strobes are decoded again per output
  logic do_live_q;
  logic do_cum_q;
  logic do_mask_q;
  logic do_fault_q;
  logic do_srq_wr;
  logic do_srq_q;
  logic do_pon_wr;
  logic do_pon_q;
  logic do_err_q;
  logic do_poll;

  assign do_live_q = cmd_valid && (cmd_op == OP_LIVE_STATUS_QUERY);
  assign do_cum_q = cmd_valid && (cmd_op == OP_CUMULATIVE_STATUS_QUERY);
  assign do_mask_q = cmd_valid && (cmd_op == OP_MASK_QUERY);
  assign do_fault_q = cmd_valid && (cmd_op == OP_FAULT_QUERY);
  assign do_srq_wr = cmd_valid && (cmd_op == OP_SRQ_ENABLE_WRITE);
  assign do_srq_q = cmd_valid && (cmd_op == OP_SRQ_ENABLE_QUERY);
  assign do_pon_wr = cmd_valid && (cmd_op == OP_PON_ENABLE_WRITE);
  assign do_pon_q = cmd_valid && (cmd_op == OP_PON_ENABLE_QUERY);
  assign do_err_q = cmd_valid && (cmd_op == OP_ERROR_QUERY);
  assign do_poll = cmd_valid && (cmd_op == OP_SERIAL_POLL);

  genvar gi;
  generate
    for (gi = 0; gi < OSFSR_MAX_OUT; gi++) begin : g_out
      if (gi < NUM_OUT) begin : g_present
        osfsr_chan_if ch_if ();
        assign ch_if.live_raw = live_status_pins[gi*OSFSR_W +: OSFSR_W];
        assign ch_if.rd_cum = cmd_valid && chan_hit(cmd_op, OP_CUMULATIVE_STATUS_QUERY,
                                                    cmd_chan, gi);
        assign ch_if.rd_fault = cmd_valid && chan_hit(cmd_op, OP_FAULT_QUERY, cmd_chan, gi);
        assign ch_if.wr_mask = cmd_valid && chan_hit(cmd_op, OP_MASK_WRITE, cmd_chan, gi);
        assign ch_if.reprog = do_reprog && (int'(cmd_chan) == gi);
        assign ch_if.mask_data = cmd_data;
        assign ch_if.clr = do_clear;
        osfsr_chan u_chan (
          .clk_sys(clk_sys),
          .rst(rst),
          .ch(ch_if.unit)
        );
        assign live_arr[gi] = ch_if.live;
        assign cum_arr[gi] = ch_if.cum;
        assign mask_arr[gi] = ch_if.mask;
        assign fault_arr[gi] = ch_if.fault;
      end else begin : g_absent
        // Missing outputs read as all zero
        assign live_arr[gi] = 8'h00;
        assign cum_arr[gi] = 8'h00;
        assign mask_arr[gi] = 8'h00;
        assign fault_arr[gi] = 8'h00;
      end
      // Plain OR, so the summary drops with the last fault bit of its output
      assign fault_summary[gi] = |fault_arr[gi];
    end
  endgenerate

  // ==========================================================================
  // State
  typedef struct packed {
    logic drop_sync1;
    logic drop_sync2;
    logic drop_prev;
    logic nv_sync1;
    logic nv_sync2;
    logic [1:0] boot_cnt;
    logic booted;
    logic pon_en;
    logic [1:0] srq_en;
    logic err;
    logic request_service_flag;
    logic power_on_flag;
    logic ready;
    logic cond_prev;
    logic resp_valid;
    logic [7:0] resp_data;
    logic [7:0] poll;
  } osfsr_core_st_t;

  osfsr_core_st_t st_reg;
  osfsr_core_st_t st_next;
  logic pon_event;
  logic srq_cond;
  logic srq_event;
  logic boot_load;
  logic drop_edge;
  logic fault_req;
  logic err_req;
  logic chan_ok;
  logic [7:0] poll_now;

  // ==========================================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    pon_event = 1'b0;
    chan_ok = int'(cmd_chan) < NUM_OUT;
    // Pins pass two flip-flops before any other logic looks at them
    st_next.drop_sync1 = dropout_pin;
    st_next.drop_sync2 = st_reg.drop_sync1;
    st_next.drop_prev = st_reg.drop_sync2;
    st_next.nv_sync1 = nv_pon_pin;
    st_next.nv_sync2 = st_reg.nv_sync1;
    // Ready is registered from busy, so it lags processing by one cycle
    st_next.ready = ~busy;
    st_next.resp_valid = 1'b0;

    // Power events: the boot load, or a dropout edge once booted
    boot_load = !st_reg.booted && (st_reg.boot_cnt == PON_LOAD_CYCLES);
    drop_edge = st_reg.booted && st_reg.drop_sync2 && !st_reg.drop_prev;

    // Stored enable is taken once the synchroniser has settled after reset
    if (!st_reg.booted) begin
      if (st_reg.boot_cnt == PON_LOAD_CYCLES) begin
        st_next.booted = 1'b1;
        st_next.pon_en = st_reg.nv_sync2;
        pon_event = st_reg.nv_sync2;
      end else begin
        st_next.boot_cnt = st_reg.boot_cnt + 2'h1;
      end
    end
    // A dropout edge is a power event that requests per the current power-on enable, with no reload from the stored pin
    if (drop_edge) begin
      pon_event = st_reg.pon_en;
    end

    // Power-on flag: device clear loses to a same-cycle power event
    if (do_clear) begin
      st_next.power_on_flag = 1'b0;
      st_next.srq_en = SRQ_EN_RESET;
    end
    if (boot_load || drop_edge) begin
      st_next.power_on_flag = 1'b1;
    end

    // Error flag: query clears, a new error in the same cycle wins
    if (do_err_q) begin
      st_next.err = 1'b0;
    end
    if (error_event) begin
      st_next.err = 1'b1;
    end

    // Settings; a write and a device clear never share an edge, one op per command
    if (do_srq_wr) begin
      st_next.srq_en = cmd_data[1:0];
    end
    if (do_pon_wr) begin
      st_next.pon_en = cmd_data[0];
    end

    // Request on the rising edge of the enabled condition, so a poll is not
    // immediately undone by a fault that is still standing
    fault_req = st_reg.srq_en[SRQ_EN_FAULT] && (|fault_summary);
    err_req = st_reg.srq_en[SRQ_EN_ERROR] && st_reg.err;
    srq_cond = fault_req || err_req;
    st_next.cond_prev = srq_cond;
    srq_event = (srq_cond && !st_reg.cond_prev) || pon_event;
    if (do_poll) begin
      st_next.request_service_flag = 1'b0;
    end
    if (srq_event) begin
      st_next.request_service_flag = 1'b1;
    end

    // Poll answer is taken before this edge clears the request flag
    poll_now = {st_reg.power_on_flag, st_reg.request_service_flag, st_reg.err, st_reg.ready, fault_summary};
    st_next.poll = {st_next.power_on_flag, st_next.request_service_flag, st_next.err, st_next.ready, fault_summary};

    // Query answers, one cycle after the command
    if (cmd_valid) begin
      st_next.resp_data = 8'h00;
      // Channels outside the build answer zero rather than a stale neighbour
      if (do_live_q) begin
        st_next.resp_valid = 1'b1;
        st_next.resp_data = chan_ok ? live_arr[cmd_chan] : 8'h00;
      end else if (do_cum_q) begin
        st_next.resp_valid = 1'b1;
        st_next.resp_data = chan_ok ? cum_arr[cmd_chan] : 8'h00;
      end else if (do_mask_q) begin
        st_next.resp_valid = 1'b1;
        st_next.resp_data = chan_ok ? mask_arr[cmd_chan] : 8'h00;
      end else if (do_fault_q) begin
        st_next.resp_valid = 1'b1;
        st_next.resp_data = chan_ok ? fault_arr[cmd_chan] : 8'h00;
      end else if (do_srq_q) begin
        st_next.resp_valid = 1'b1;
        st_next.resp_data = {6'h00, st_reg.srq_en};
      end else if (do_pon_q) begin
        st_next.resp_valid = 1'b1;
        st_next.resp_data = {7'h00, st_reg.pon_en};
      end else if (do_err_q) begin
        // Error code table lives elsewhere; only the flag is returned here
        st_next.resp_valid = 1'b1;
        st_next.resp_data = {7'h00, st_reg.err};
      end else if (do_poll) begin
        st_next.resp_valid = 1'b1;
        st_next.resp_data = poll_now;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flip-flops
  assign resp_valid = st_reg.resp_valid;
  assign resp_data = st_reg.resp_data;
  // Lamp and bus line share one flop, so they can never disagree
  assign srq_out = st_reg.request_service_flag;
  assign srq_lamp = st_reg.request_service_flag;
  assign err_lamp = st_reg.err;
  assign nv_pon_store = st_reg.pon_en;
  assign poll_byte = st_reg.poll;

endmodule : osfsr_core
`default_nettype wire

// ### hw/osfsr_pkg.sv
// Package of constants and types for the output status, fault and service request block.
// Assumes one clock domain and at most four output channels.
package osfsr_pkg;

  // ==========================================================================
  // Sizes
  localparam int OSFSR_MAX_OUT = 4;
  localparam int OSFSR_W = 8;
  localparam int OSFSR_CHAN_W = 2;

  // ==========================================================================
  // Per-output status layout, shared by live, cumulative, mask and fault
  localparam int BIT_CONSTANT_VOLTAGE = 0;
  localparam int BIT_POSITIVE_LIMIT = 1;
  localparam int BIT_NEGATIVE_LIMIT = 2;
  localparam int BIT_OVERVOLTAGE_TRIP = 3;
  localparam int BIT_OVERTEMP_TRIP = 4;
  localparam int BIT_UNREGULATED = 5;
  localparam int BIT_OVERCURRENT_TRIP = 6;
  localparam int BIT_COUPLED_PARAM = 7;
  // Bits that a reprogramming command may force into the fault register
  localparam logic [7:0] REPROG_FAULT_BITS = 8'h27;

  // ==========================================================================
  // Poll summary status layout
  localparam int POLL_FAULT_LSB = 0;
  localparam int POLL_READY = 4;
  localparam int POLL_ERROR = 5;
  localparam int POLL_REQUEST = 6;
  localparam int POLL_POWER_ON = 7;

  // ==========================================================================
  // Service request enable setting and reset values
  localparam int SRQ_EN_FAULT = 0;
  localparam int SRQ_EN_ERROR = 1;
  localparam logic [1:0] SRQ_EN_RESET = 2'h0;
  localparam logic [7:0] REG8_RESET = 8'h00;
  // Cycles after reset release before the stored power-on enable is taken
  localparam logic [1:0] PON_LOAD_CYCLES = 2'h2;

  // ==========================================================================
  // Command port operations
  typedef enum logic [3:0] {
    OP_LIVE_STATUS_QUERY,
    OP_CUMULATIVE_STATUS_QUERY,
    OP_MASK_WRITE,
    OP_MASK_QUERY,
    OP_FAULT_QUERY,
    OP_SRQ_ENABLE_WRITE,
    OP_SRQ_ENABLE_QUERY,
    OP_PON_ENABLE_WRITE,
    OP_PON_ENABLE_QUERY,
    OP_ERROR_QUERY,
    OP_DEVICE_CLEAR,
    OP_SERIAL_POLL,
    OP_REPROGRAM
  } osfsr_op_t;

endpackage : osfsr_pkg

// ### hw/osfsr_chan_if.sv
// Interface between the core and one output channel unit.
// Strobes are one-cycle pulses on clk_sys; the unit's outputs are registers.
`timescale 1ns/100ps
`default_nettype none
interface osfsr_chan_if;
  logic [7:0] live_raw;
  logic rd_cum;
  logic rd_fault;
  logic wr_mask;
  logic [7:0] mask_data;
  logic reprog;
  logic clr;
  logic [7:0] live;
  logic [7:0] cum;
  logic [7:0] mask;
  logic [7:0] fault;
  modport unit (
    input live_raw, rd_cum, rd_fault, wr_mask, mask_data, reprog, clr,
    output live, cum, mask, fault
  );
  modport ctrl (
    output live_raw, rd_cum, rd_fault, wr_mask, mask_data, reprog, clr,
    input live, cum, mask, fault
  );
endinterface : osfsr_chan_if
`default_nettype wire

// ### hw/osfsr_chan.sv
// One output channel: synchronised live status, cumulative status, mask and fault.
// Live status comes from analog pins and is synchronised here; strobes are on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module osfsr_chan
  import osfsr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  osfsr_chan_if.unit ch
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] live;
    logic [7:0] live_prev;
    logic [7:0] cum;
    logic [7:0] mask;
    logic [7:0] fault;
  } osfsr_chan_st_t;

  osfsr_chan_st_t st_reg;
  osfsr_chan_st_t st_next;
  logic [7:0] rise;
  logic [7:0] unmask_rise;

  // ==========================================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.sync1 = ch.live_raw;
    st_next.live = st_reg.sync1;
    st_next.live_prev = st_reg.live;
    rise = st_reg.live & ~st_reg.live_prev;
    unmask_rise = 8'h00;
    // Sticky accumulation; a read reloads from live status
    if (ch.rd_cum) begin
      st_next.cum = st_reg.live;
    end else begin
      st_next.cum = st_reg.cum | st_reg.live;
    end
    // Mask changes only from the command port
    if (ch.clr) begin
      st_next.mask = REG8_RESET;
    end else if (ch.wr_mask) begin
      st_next.mask = ch.mask_data;
      unmask_rise = ch.mask_data & ~st_reg.mask;
    end
    // Read clears, but a new cause in the same cycle survives the clear
    if (ch.rd_fault || ch.clr) begin
      st_next.fault = REG8_RESET;
    end
    st_next.fault = st_next.fault | (rise & st_reg.mask);
    st_next.fault = st_next.fault | (unmask_rise & st_reg.live);
    if (ch.reprog) begin
      st_next.fault = st_next.fault | (REPROG_FAULT_BITS & st_reg.live & st_reg.mask);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ch.live = st_reg.live;
  assign ch.cum = st_reg.cum;
  assign ch.mask = st_reg.mask;
  assign ch.fault = st_reg.fault;

endmodule : osfsr_chan
`default_nettype wire

// ### dv/osfsr_core_sva.sv
// Port checker for osfsr_core.
// Sees only the core's ports; bound to it at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module osfsr_core_sva
  import osfsr_pkg::*;
#(
  parameter int NUM_OUT = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [NUM_OUT*OSFSR_W-1:0] live_status_pins,
  input wire logic dropout_pin,
  input wire logic nv_pon_pin,
  input wire logic busy,
  input wire logic error_event,
  input wire logic cmd_valid,
  input wire osfsr_op_t cmd_op,
  input wire logic [OSFSR_CHAN_W-1:0] cmd_chan,
  input wire logic [7:0] cmd_data,
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  input wire logic srq_out,
  input wire logic srq_lamp,
  input wire logic err_lamp,
  input wire logic nv_pon_store,
  input wire logic [7:0] poll_byte
);
  // ==========================================================================
  // Helpers
  // Age gates checks whose history would reach back into reset
  logic [1:0] age_reg;
  logic [3:0] drop_reg;
  logic [1:0] en_reg;
  logic query;
  assign query = cmd_valid && !(cmd_op inside {OP_MASK_WRITE, OP_SRQ_ENABLE_WRITE,
    OP_PON_ENABLE_WRITE, OP_DEVICE_CLEAR, OP_REPROGRAM});
  always_ff @(posedge clk_sys) begin
    drop_reg <= {drop_reg[2:0], dropout_pin};
    if (rst) begin
      age_reg <= 2'h0;
      en_reg <= 2'h0;
    end else begin
      if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
      if (cmd_valid && cmd_op == OP_SRQ_ENABLE_WRITE) en_reg <= cmd_data[1:0];
      else if (cmd_valid && cmd_op == OP_DEVICE_CLEAR) en_reg <= 2'h0;
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_lamp_follows_req: assert property (srq_lamp == srq_out)
    else $error("service lamp differs from request line");
  a_err_sets: assert property (error_event |-> ##[1:2] err_lamp)
    else $error("error lamp not lit after error");
  a_err_clears: assert property (cmd_valid && cmd_op == OP_ERROR_QUERY && !error_event
    ##1 !error_event |-> ##[0:1] !err_lamp) else $error("error lamp not cleared");
  a_query_answers: assert property (query |=> resp_valid)
    else $error("query without answer");
  a_ready_tracks: assert property (age_reg == 2'h3 |-> poll_byte[4] == !$past(busy))
    else $error("ready bit wrong");
  a_absent_summary: assert property ((poll_byte[3:0] >> NUM_OUT) == 4'h0)
    else $error("absent output shows fault");
  a_pon_store: assert property (cmd_valid && cmd_op == OP_PON_ENABLE_WRITE && cmd_data[0]
    |-> ##[1:2] nv_pon_store) else $error("power-on enable not stored");
  a_clear_pon: assert property (cmd_valid && cmd_op == OP_DEVICE_CLEAR && age_reg == 2'h3
    && drop_reg == 4'h0 && !dropout_pin |-> ##2 !poll_byte[7]) else $error("pon not cleared");
  a_err_requests: assert property (error_event && en_reg[1] && !err_lamp && !srq_out
    |-> ##[1:4] srq_out) else $error("no request on enabled error");
endmodule : osfsr_core_sva
bind osfsr_core osfsr_core_sva #(.NUM_OUT(NUM_OUT)) u_osfsr_core_sva (.clk_sys(clk_sys),
  .rst(rst), .live_status_pins(live_status_pins), .dropout_pin(dropout_pin),
  .nv_pon_pin(nv_pon_pin), .busy(busy), .error_event(error_event), .cmd_valid(cmd_valid),
  .cmd_op(cmd_op), .cmd_chan(cmd_chan), .cmd_data(cmd_data), .resp_valid(resp_valid),
  .resp_data(resp_data), .srq_out(srq_out), .srq_lamp(srq_lamp), .err_lamp(err_lamp),
  .nv_pon_store(nv_pon_store), .poll_byte(poll_byte));
`default_nettype wire

// ### dv/osfsr_ctrl_model.sv
// Bus controller model: issues commands and serial polls, collects answers.
// Drives after the falling edge; answer sampled at the next falling edge, half a cycle after the taking edge.
`timescale 1ns/100ps
`default_nettype none
module osfsr_ctrl_model
  import osfsr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  output logic cmd_valid,
  output var osfsr_op_t cmd_op,
  output logic [1:0] cmd_chan,
  output logic [7:0] cmd_data
);
  // ==========================================================================
  // Command issue
  initial begin
    cmd_valid = 1'b0;
    cmd_op = OP_SERIAL_POLL;
    cmd_chan = 2'h0;
    cmd_data = 8'h00;
  end
  task automatic cmd(input osfsr_op_t op, input logic [1:0] ch, input logic [7:0] d,
                     output logic got, output logic [7:0] r);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_chan = ch;
    cmd_data = d;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    // Released fields are inverted so a stale value is never mistaken for a command
    cmd_chan = ~ch;
    cmd_data = ~d;
    got = resp_valid;
    r = resp_data;
  endtask : cmd
endmodule : osfsr_ctrl_model
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for osfsr_core built with three outputs.
// Controller model drives commands; the bench drives status and event pins.
`timescale 1ns/100ps
`default_nettype none
module testbench
  import osfsr_pkg::*;
;
  localparam int NOUT = 3;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [NOUT*8-1:0] live = 24'h000000;
  logic dropout_pin = 1'b0;
  logic nv_pon_pin = 1'b1;
  logic busy = 1'b0;
  logic error_event = 1'b0;
  logic cmd_valid, resp_valid, srq_out, srq_lamp, err_lamp, nv_pon_store, got;
  osfsr_op_t cmd_op;
  logic [1:0] cmd_chan;
  logic [7:0] cmd_data, resp_data, poll_byte, r;
  int fail_count = 0;
  int check_count = 0;
  always #20 clk_sys = ~clk_sys;
  osfsr_core #(.NUM_OUT(NOUT)) u_osfsr_core (.clk_sys(clk_sys), .rst(rst),
    .live_status_pins(live), .dropout_pin(dropout_pin), .nv_pon_pin(nv_pon_pin),
    .busy(busy), .error_event(error_event), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_chan(cmd_chan), .cmd_data(cmd_data), .resp_valid(resp_valid),
    .resp_data(resp_data), .srq_out(srq_out), .srq_lamp(srq_lamp), .err_lamp(err_lamp),
    .nv_pon_store(nv_pon_store), .poll_byte(poll_byte));
  osfsr_ctrl_model u_osfsr_ctrl_model (.clk_sys(clk_sys), .resp_valid(resp_valid),
    .resp_data(resp_data), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_chan(cmd_chan),
    .cmd_data(cmd_data));
  // ==========================================================================
  // Shared tasks
  task automatic w(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : w
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input osfsr_op_t op, input logic [1:0] ch, input logic [7:0] d);
    u_osfsr_ctrl_model.cmd(op, ch, d, got, r);
  endtask : wr
  // A missing answer turns the data unknown so the compare fails
  task automatic q(input string what, input osfsr_op_t op, input logic [1:0] ch,
                   input logic [7:0] exp);
    u_osfsr_ctrl_model.cmd(op, ch, 8'h00, got, r);
    if (got !== 1'b1) r = 8'hxx;
    chk(what, exp, r);
  endtask : q
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  // ==========================================================================
  // Scenarios
  task automatic t_power_on();
    w(8);
    q("poll", OP_SERIAL_POLL, 2'h0, 8'hd0);
    q("poll again", OP_SERIAL_POLL, 2'h0, 8'h90);
    q("pon enable", OP_PON_ENABLE_QUERY, 2'h0, 8'h01);
    wr(OP_DEVICE_CLEAR, 2'h0, 8'h00);
    w(2);
    chk("poll byte", 8'h10, poll_byte);
  endtask : t_power_on
  task automatic t_cumulative();
    live[15:8] = 8'h08;
    w(4);
    live[15:8] = 8'h01;
    w(4);
    q("cumulative", OP_CUMULATIVE_STATUS_QUERY, 2'h1, 8'h09);
    q("cumulative reload", OP_CUMULATIVE_STATUS_QUERY, 2'h1, 8'h01);
    q("live", OP_LIVE_STATUS_QUERY, 2'h1, 8'h01);
  endtask : t_cumulative
  task automatic t_fault();
    wr(OP_SRQ_ENABLE_WRITE, 2'h0, 8'h01);
    wr(OP_MASK_WRITE, 2'h0, 8'h08);
    live[7:0] = 8'h08;
    w(8);
    chk("request line", 8'h01, {7'h00, srq_out});
    live[7:0] = 8'h00;
    w(4);
    q("poll", OP_SERIAL_POLL, 2'h0, 8'h51);
    q("poll again", OP_SERIAL_POLL, 2'h0, 8'h11);
    chk("request line", 8'h00, {7'h00, srq_out});
    q("fault", OP_FAULT_QUERY, 2'h0, 8'h08);
    q("fault reread", OP_FAULT_QUERY, 2'h0, 8'h00);
    q("poll", OP_SERIAL_POLL, 2'h0, 8'h10);
  endtask : t_fault
  task automatic t_unmask();
    wr(OP_DEVICE_CLEAR, 2'h0, 8'h00);
    live[23:16] = 8'h20;
    w(4);
    wr(OP_MASK_WRITE, 2'h2, 8'h20);
    w(2);
    q("fault on unmask", OP_FAULT_QUERY, 2'h2, 8'h20);
    q("fault reread", OP_FAULT_QUERY, 2'h2, 8'h00);
    wr(OP_REPROGRAM, 2'h2, 8'h00);
    w(2);
    q("fault on reprogram", OP_FAULT_QUERY, 2'h2, 8'h20);
    q("mask", OP_MASK_QUERY, 2'h2, 8'h20);
    wr(OP_MASK_WRITE, 2'h3, 8'hff);
    q("absent mask", OP_MASK_QUERY, 2'h3, 8'h00);
  endtask : t_unmask
  task automatic t_errors();
    for (int e = 0; e < 4; e++) begin
      wr(OP_SRQ_ENABLE_WRITE, 2'h0, 8'(e));
      q("request enable", OP_SRQ_ENABLE_QUERY, 2'h0, 8'(e));
      error_event = 1'b1;
      w(1);
      error_event = 1'b0;
      w(6);
      chk("error lamp", 8'h01, {7'h00, err_lamp});
      chk("request line", {7'h00, e[1]}, {7'h00, srq_out});
      q("poll", OP_SERIAL_POLL, 2'h0, {1'b0, e[1], 6'h30});
      q("error", OP_ERROR_QUERY, 2'h0, 8'h01);
      w(2);
      chk("error lamp", 8'h00, {7'h00, err_lamp});
    end
  endtask : t_errors
  task automatic t_ready();
    busy = 1'b1;
    w(3);
    q("poll busy", OP_SERIAL_POLL, 2'h0, 8'h00);
    busy = 1'b0;
    w(3);
    chk("ready", 8'h10, poll_byte);
  endtask : t_ready
  task automatic t_dropout();
    for (int p = 0; p < 2; p++) begin
      wr(OP_PON_ENABLE_WRITE, 2'h0, 8'(p));
      wr(OP_DEVICE_CLEAR, 2'h0, 8'h00);
      chk("stored enable", 8'(p), {7'h00, nv_pon_store});
      dropout_pin = 1'b1;
      w(3);
      dropout_pin = 1'b0;
      w(8);
      q("poll", OP_SERIAL_POLL, 2'h0, {1'b1, p[0], 6'h10});
    end
  endtask : t_dropout
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    w(3);
    rst = 1'b0;
    t_power_on();
    t_cumulative();
    t_fault();
    t_unmask();
    t_errors();
    t_ready();
    t_dropout();
    end_sim();
  end
  // Tests take a few hundred cycles; ten thousand leaves ample margin
  initial begin
    #400000;
    fail_count++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire
